/* rtl/sep_dev.sv */
`timescale 1ns/1ps
// Operation
// - Low pause suspends transfer, keeps progress
// - Host lowers pause only with clock low
// - Host raises pause only with clock low
// - Power-up: standby, no instruction in progress
// - No instruction before select falling edge
// - Output undriven until read data
// - Write latch cleared at power-up
// - Latch set only by set command
// - Write starts only at permitted count
// - Guard low clears write latch
// - Host waits 1 ms before reads
// - Host waits 5 ms before writes
// - Set 06h, clear 04h, MSB first
// - Permitted counts: 24, 32, 40, 48
// - Completed write cycle clears latch
// - Resume at the paused bit position
module sep_dev (
  sep_if.dev link,
  input wire logic core_clk_i,
  input wire logic rst_i,
  output logic latch_o,
  output logic busy_o,
  output logic armed_o
);
  localparam int AW = sep_pkg::ADDR_W;
  localparam int DW = sep_pkg::DATA_W;
  localparam int PW = sep_pkg::PAGE_W;

  // Link side state
  logic [5:0] bit_cnt;
  logic over;
  logic [5:0] last_cnt;
  logic last_over;
  logic [7:0] sh;
  logic [7:0] opcode;
  logic [AW-1:0] addr;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] page [2**PW];
  logic [2:0] armed_l;
  logic so_drv;
  logic so_bit;
  logic [DW-1:0] rd_data;

  // Core side state
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_flt;
  wire logic [1:0] next_flt;
  logic [AW-1:0] wr_base;
  logic [2:0] wr_n;
  logic [PW-1:0] wr_idx;

  // Link side decode
  wire logic [5:0] next_cnt = bit_cnt + 6'h01;
  wire logic next_over = over | (bit_cnt == 6'h3F);
  wire logic [7:0] next_byte = {sh[6:0], link.serial_in};
  wire logic byte_end = (next_cnt[2:0] == 3'h0);
  wire logic hdr_done = over || (bit_cnt >= sep_pkg::HDR_BITS);
  wire logic in_data = next_over || (next_cnt > sep_pkg::HDR_BITS);
  wire logic is_read = (opcode == sep_pkg::OP_READ);
  wire logic is_write = (opcode == sep_pkg::OP_WRITE);
  wire logic rd_phase = is_read && hdr_done;
  wire logic [PW-1:0] slot = addr[PW-1:0] + next_cnt[4:3] + 2'h1;
  wire logic [2:0] out_pos = 3'h7 - bit_cnt[2:0];
  wire logic taken = !link.select_n && link.pause_n;

  // Bit counter, held clear while deselected
  always_ff @(posedge link.link_clk or posedge link.select_n) begin
    if (link.select_n) begin
      bit_cnt <= 6'h00;
      over <= 1'b0;
    end else if (link.pause_n) begin
      bit_cnt <= next_cnt;
      over <= next_over;
    end
  end

  // Shift path; values stay put after select rises for the core side
  always_ff @(posedge link.link_clk) begin
    if (taken) begin
      sh <= next_byte;
      last_cnt <= next_cnt;
      last_over <= next_over;
      if (!over && next_cnt == sep_pkg::CMD_BITS) begin
        opcode <= next_byte;
      end
      if (!over && next_cnt == sep_pkg::HDR_BITS) begin
        addr <= next_byte;
      end
      if (is_write && in_data && byte_end) begin
        page[slot] <= next_byte;
      end
    end
  end

  // Read address: loaded after the header, then steps per byte
  always_ff @(posedge link.link_clk) begin
    if (taken) begin
      if (!over && next_cnt == sep_pkg::HDR_BITS) begin
        rd_addr <= next_byte;
      end else if (rd_phase && byte_end) begin
        rd_addr <= rd_addr + 8'h01;
      end
    end
  end

  // Armed flag brought over to the link clock
  always_ff @(posedge link.link_clk or posedge link.select_n) begin
    if (link.select_n) begin
      armed_l <= 3'h0;
    end else begin
      armed_l <= {armed_l[1:0], armed_o};
    end
  end

  // Output drive changes on the falling edge
  always_ff @(negedge link.link_clk or posedge link.select_n) begin
    if (link.select_n) begin
      so_drv <= 1'b0;
    end else if (link.pause_n) begin
      so_drv <= rd_phase && armed_l[2] && armed_l[1];
    end
  end

  always_ff @(negedge link.link_clk) begin
    if (taken) begin
      so_bit <= rd_data[out_pos];
    end
  end

  assign link.serial_out = so_bit;
  assign link.serial_out_oe_n = ~(so_drv & link.pause_n);

  // Select and guard pins into the core clock
  wire logic [1:0] pin_raw = {link.write_guard_n, link.select_n};

  always_ff @(posedge core_clk_i) begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  generate
    for (genvar i = 0; i < 2; i++) begin : g_flt
      assign next_flt[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : pin_flt[i];
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          pin_flt[i] <= 1'b1;
        end else begin
          pin_flt[i] <= next_flt[i];
        end
      end
    end
  endgenerate

  // Frame decode at the rise of select
  wire logic sel_fall = pin_flt[0] & ~next_flt[0];
  wire logic sel_rise = ~pin_flt[0] & next_flt[0];
  wire logic guard_ok = pin_flt[1];
  wire logic frame_end = sel_rise && armed_o;
  wire logic cmd_ok = frame_end && !last_over && (last_cnt == sep_pkg::CMD_BITS);
  wire logic set_req = cmd_ok && (opcode == sep_pkg::OP_SET_LATCH);
  wire logic clr_req = cmd_ok && (opcode == sep_pkg::OP_CLR_LATCH);
  wire logic cnt_ok = !last_over && ((last_cnt == sep_pkg::WR_CNT_1) ||
    (last_cnt == sep_pkg::WR_CNT_2) || (last_cnt == sep_pkg::WR_CNT_3) ||
    (last_cnt == sep_pkg::WR_CNT_4));
  wire logic wr_start = frame_end && is_write && latch_o && guard_ok &&
    cnt_ok && !busy_o;

  // Write engine, one byte per core cycle
  wire logic [PW-1:0] wr_slot = wr_base[PW-1:0] + wr_idx;
  wire logic wr_last = busy_o && (({1'b0, wr_idx} + 3'h1) == wr_n);
  wire logic [AW-1:0] wr_addr = {wr_base[AW-1:PW], wr_slot};

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      wr_idx <= '0;
      wr_n <= 3'h0;
      wr_base <= '0;
    end else if (wr_start) begin
      busy_o <= 1'b1;
      wr_idx <= '0;
      wr_n <= last_cnt[5:3] - 3'h2;
      wr_base <= addr;
    end else if (busy_o) begin
      busy_o <= !wr_last;
      wr_idx <= wr_idx + 2'h1;
    end
  end

  // Write latch
  wire logic next_latch = !guard_ok ? 1'b0 :
    wr_last ? 1'b0 :
    set_req ? 1'b1 :
    clr_req ? 1'b0 : latch_o;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      latch_o <= 1'b0;
    end else begin
      latch_o <= next_latch;
    end
  end

  // Instructions accepted only after a select fall since power-up
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      armed_o <= 1'b0;
    end else if (sel_fall) begin
      armed_o <= 1'b1;
    end
  end

  sep_mem #(
    .AW(AW),
    .DW(DW)
  ) u_mem (
    .wr_clk_i(core_clk_i),
    .wr_en_i(busy_o),
    .wr_addr_i(wr_addr),
    .wr_data_i(page[wr_slot]),
    .rd_addr_i(rd_addr),
    .rd_data_o(rd_data)
  );
endmodule // sep_dev

/* rtl/sep_host.sv */
`timescale 1ns/1ps
module sep_host #(
  parameter int PUR_CYC = sep_pkg::PUR_CYC,
  parameter int PUW_CYC = sep_pkg::PUW_CYC,
  parameter int HALF_CYC = sep_pkg::HALF_CYC
) (
  sep_if.host link,
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input sep_pkg::sep_cmd_t cmd_op_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [31:0] cmd_data_i,
  input wire logic [2:0] cmd_len_i,
  input wire logic pause_i,
  input wire logic guard_n_i,
  output logic cmd_ready_o,
  output logic rd_ok_o,
  output logic wr_ok_o,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o
);
  typedef enum {IDLE, LEAD, LOW, HIGH, LAG, GAP} sep_hst_t;

  sep_hst_t state;
  logic [7:0] tmr;
  logic [5:0] sent;
  logic [5:0] nbits;
  logic [55:0] tx;
  logic [31:0] rx;
  logic [31:0] pu_cnt;
  logic sel_n;
  logic sclk;
  logic mosi;
  logic pause_n;
  logic guard_n;
  logic so_s1;
  logic so_s2;
  logic so_s3;
  logic so_flt;

  assign link.select_n = sel_n;
  assign link.link_clk = sclk;
  assign link.serial_in = mosi;
  assign link.pause_n = pause_n;
  assign link.write_guard_n = guard_n;

  wire logic [7:0] op_code = (cmd_op_i == sep_pkg::SEP_SET) ? sep_pkg::OP_SET_LATCH :
    (cmd_op_i == sep_pkg::SEP_CLR) ? sep_pkg::OP_CLR_LATCH :
    (cmd_op_i == sep_pkg::SEP_RD) ? sep_pkg::OP_READ : sep_pkg::OP_WRITE;
  wire logic short_cmd = (cmd_op_i == sep_pkg::SEP_SET) || (cmd_op_i == sep_pkg::SEP_CLR);
  wire logic [5:0] cmd_bits = short_cmd ? sep_pkg::CMD_BITS :
    {cmd_len_i, 3'h0} + sep_pkg::HDR_BITS;
  wire logic op_ok = (cmd_op_i == sep_pkg::SEP_RD) ? rd_ok_o : wr_ok_o;
  wire logic take = (state == IDLE) && cmd_valid_i && cmd_ready_o && op_ok;
  wire logic [7:0] half = 8'(HALF_CYC);
  wire logic tmr_done = (tmr == 8'h00);
  wire logic last_bit = ((sent + 6'h01) == nbits);

  // Power-up wait before reads and writes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pu_cnt <= 32'h0;
      rd_ok_o <= 1'b0;
      wr_ok_o <= 1'b0;
    end else begin
      if (!wr_ok_o) begin
        pu_cnt <= pu_cnt + 32'h1;
      end
      rd_ok_o <= rd_ok_o || (pu_cnt >= 32'(PUR_CYC));
      wr_ok_o <= wr_ok_o || (pu_cnt >= 32'(PUW_CYC));
    end
  end

  // Returned data line into the core clock
  always_ff @(posedge core_clk_i) begin
    so_s1 <= link.so_line;
    so_s2 <= so_s1;
    so_s3 <= so_s2;
    if (rst_i) begin
      so_flt <= 1'b1;
    end else if (so_s2 == so_s3) begin
      so_flt <= so_s3;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      guard_n <= 1'b1;
    end else begin
      guard_n <= guard_n_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= IDLE;
      tmr <= 8'h00;
      sent <= 6'h00;
      nbits <= 6'h00;
      tx <= 56'h0;
      rx <= 32'h0;
      sel_n <= 1'b1;
      sclk <= 1'b0;
      mosi <= 1'b0;
      pause_n <= 1'b1;
      cmd_ready_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 32'h0;
    end else begin
      rd_valid_o <= 1'b0;
      cmd_ready_o <= 1'b0;
      unique case (state)
        IDLE: begin
          cmd_ready_o <= !take;
          if (take) begin
            // Every command opens with a select falling edge
            sel_n <= 1'b0;
            tx <= {op_code, cmd_addr_i, cmd_data_i, 8'h00};
            mosi <= op_code[7];
            nbits <= cmd_bits;
            sent <= 6'h00;
            tmr <= 8'(sep_pkg::LEAD_CYC);
            state <= LEAD;
          end
        end
        LEAD: begin
          tmr <= tmr_done ? half : tmr - 8'h01;
          if (tmr_done) begin
            state <= LOW;
          end
        end
        LOW: begin
          if (!tmr_done) begin
            tmr <= tmr - 8'h01;
          end else if (pause_i) begin
            pause_n <= 1'b0;
          end else if (!pause_n) begin
            pause_n <= 1'b1;
            tmr <= half;
          end else begin
            sclk <= 1'b1;
            tmr <= half;
            state <= HIGH;
            if (sent >= sep_pkg::HDR_BITS) begin
              rx <= {rx[30:0], so_flt};
            end
          end
        end
        HIGH: begin
          tmr <= tmr_done ? half : tmr - 8'h01;
          if (tmr_done) begin
            sclk <= 1'b0;
            sent <= sent + 6'h01;
            tx <= {tx[54:0], 1'b0};
            mosi <= tx[54];
            state <= last_bit ? LAG : LOW;
            if (last_bit) begin
              tmr <= 8'(sep_pkg::LAG_CYC);
            end
          end
        end
        LAG: begin
          tmr <= tmr_done ? 8'(sep_pkg::LAG_CYC) : tmr - 8'h01;
          if (tmr_done) begin
            // Select rises LAG_CYC + 1 core cycles after the last clock falls, with no further clock: count is exact
            sel_n <= 1'b1;
            rd_valid_o <= 1'b1;
            rd_data_o <= rx;
            state <= GAP;
          end
        end
        GAP: begin
          tmr <= tmr - 8'h01;
          if (tmr_done) begin
            cmd_ready_o <= 1'b1;
            state <= IDLE;
          end
        end
      endcase
    end
  end
endmodule // sep_host

/* rtl/sep_if.sv */
`timescale 1ns/1ps
interface sep_if;
  logic select_n;
  logic link_clk;
  logic serial_in;
  logic pause_n;
  logic write_guard_n;
  logic serial_out;
  logic serial_out_oe_n;
  logic so_line;
  // Pulled high while nobody drives the output line
  assign so_line = serial_out_oe_n ? 1'b1 : serial_out;
  modport host (
    output select_n, link_clk, serial_in, pause_n, write_guard_n,
    input so_line
  );
  modport dev (
    input select_n, link_clk, serial_in, pause_n, write_guard_n,
    output serial_out, serial_out_oe_n
  );
endinterface

/* rtl/sep_mem.sv */
`timescale 1ns/1ps
module sep_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic wr_clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  logic [DW-1:0] cells [2**AW];

  always_ff @(posedge wr_clk_i) begin
    if (wr_en_i) begin
      cells[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = cells[rd_addr_i];
endmodule // sep_mem

/* rtl/sep_pkg.sv */
package sep_pkg;
  // Array shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 2;
  // Instruction codes, sent most significant bit first
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  // Clock counts within one selected sequence
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] HDR_BITS = 6'h10;
  localparam logic [5:0] WR_CNT_1 = 6'h18;
  localparam logic [5:0] WR_CNT_2 = 6'h20;
  localparam logic [5:0] WR_CNT_3 = 6'h28;
  localparam logic [5:0] WR_CNT_4 = 6'h30;
  // Host timing at the core clock
  localparam int CORE_NS = 100;
  localparam int T_LEAD_NS = 500;
  localparam int T_LAG_NS = 500;
  localparam int T_SCK_NS = 1000;
  localparam int LEAD_CYC = (T_LEAD_NS + CORE_NS - 1) / CORE_NS;
  localparam int LAG_CYC = (T_LAG_NS + CORE_NS - 1) / CORE_NS;
  localparam int HALF_CYC = (T_SCK_NS / 2 + CORE_NS - 1) / CORE_NS;
  localparam int T_PUR_MS = 1;
  localparam int T_PUW_MS = 5;
  localparam int PUR_CYC = T_PUR_MS * (1000000 / CORE_NS);
  localparam int PUW_CYC = T_PUW_MS * (1000000 / CORE_NS);
  // Host user commands
  typedef enum logic [1:0] {SEP_SET, SEP_CLR, SEP_RD, SEP_WR} sep_cmd_t;
endpackage

/* testbench/sep_properties.sv */
`timescale 1ns/1ps
module sep_properties (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic select_n_i,
  input wire logic link_clk_i,
  input wire logic serial_in_i,
  input wire logic pause_n_i,
  input wire logic write_guard_n_i,
  input wire logic serial_out_i,
  input wire logic serial_out_oe_n_i,
  input wire logic so_line_i
);
  logic clk_q;
  logic [5:0] rises;
  // Counts link clock rises within one frame
  always_ff @(posedge core_clk_i) begin
    clk_q <= link_clk_i;
    if (rst_i || select_n_i) begin
      rises <= 6'h00;
    end else if (link_clk_i && !clk_q) begin
      rises <= rises + 6'h01;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  pause_fall_a: assert property ($fell(pause_n_i) |-> !link_clk_i)
    else $error("pause lowered with link clock high");
  pause_rise_a: assert property ($rose(pause_n_i) |-> !link_clk_i && !$past(link_clk_i))
    else $error("pause raised with link clock high");
  pause_hold_a: assert property (!pause_n_i |-> !link_clk_i && $stable(serial_in_i))
    else $error("link moved during pause");
  pause_quiet_a: assert property (!pause_n_i |-> serial_out_oe_n_i && so_line_i)
    else $error("output driven during pause");
  idle_quiet_a: assert property (select_n_i |-> serial_out_oe_n_i)
    else $error("output driven while deselected");
  select_first_a: assert property ($rose(link_clk_i) |-> !select_n_i)
    else $error("link clock outside frame");
  lead_time_a: assert property ($fell(select_n_i) |-> !link_clk_i [*8])
    else $error("short lead after select");
  frame_count_a: assert property ($rose(select_n_i) |->
    rises inside {6'h08, 6'h18, 6'h20, 6'h28, 6'h30})
    else $error("frame ended at bad clock count");
  data_steady_a: assert property (link_clk_i && $past(link_clk_i) |-> $stable(serial_in_i))
    else $error("data moved while link clock high");
  drive_late_a: assert property (!serial_out_oe_n_i |-> rises >= 6'h10)
    else $error("output driven before read data");
  out_hold_a: assert property (!pause_n_i |-> $stable(serial_out_i))
    else $error("output bit moved during pause");
endmodule // sep_properties

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  sep_pkg::sep_cmd_t cmd_op_i = sep_pkg::SEP_SET;
  logic [7:0] cmd_addr_i = 8'h00;
  logic [31:0] cmd_data_i = 32'h00000000;
  logic [2:0] cmd_len_i = 3'h1;
  logic pause_i = 1'b0;
  logic guard_n_i = 1'b1;
  logic cmd_ready_o, rd_ok_o, wr_ok_o, rd_valid_o, latch_o, busy_o, armed_o;
  logic [31:0] rd_data_o;
  logic [31:0] got;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  sep_if link_bus ();
  sep_host #(.PUR_CYC(20), .PUW_CYC(40), .HALF_CYC(5)) i_sep_host (.link(link_bus),
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .cmd_len_i(cmd_len_i),
    .pause_i(pause_i), .guard_n_i(guard_n_i), .cmd_ready_o(cmd_ready_o), .rd_ok_o(rd_ok_o),
    .wr_ok_o(wr_ok_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));
  sep_dev i_sep_dev (.link(link_bus), .core_clk_i(core_clk_i), .rst_i(rst_i),
    .latch_o(latch_o), .busy_o(busy_o), .armed_o(armed_o));
  sep_properties i_sep_properties (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .select_n_i(link_bus.select_n), .link_clk_i(link_bus.link_clk),
    .serial_in_i(link_bus.serial_in), .pause_n_i(link_bus.pause_n),
    .write_guard_n_i(link_bus.write_guard_n), .serial_out_i(link_bus.serial_out),
    .serial_out_oe_n_i(link_bus.serial_out_oe_n), .so_line_i(link_bus.so_line));
  always #50 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // One host command, waits for its frame end and the device write cycle
  task automatic run_cmd(input sep_pkg::sep_cmd_t op, input logic [7:0] a,
                         input logic [31:0] d, input logic [2:0] len);
    int i;
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_data_i = d;
    cmd_len_i = len;
    cmd_valid_i = 1'b1;
    for (i = 0; i < 200 && (cmd_ready_o !== 1'b1 ||
         (op == sep_pkg::SEP_RD ? rd_ok_o : wr_ok_o) !== 1'b1); i++) tick(1);
    check_bit(cmd_ready_o & (op == sep_pkg::SEP_RD ? rd_ok_o : wr_ok_o), 1'b1);
    tick(1);
    cmd_valid_i = 1'b0;
    for (i = 0; i < 1000 && rd_valid_o !== 1'b1; i++) tick(1);
    check_bit(rd_valid_o, 1'b1);
    got = rd_data_o;
    tick(8);
    for (i = 0; i < 200 && busy_o !== 1'b0; i++) tick(1);
    check_bit(busy_o, 1'b0);
  endtask
  // Pause or guard request in mid-frame
  task automatic poke(input int n, input int hold, input bit is_guard);
    tick(n);
    if (is_guard) guard_n_i = 1'b0;
    else pause_i = 1'b1;
    tick(hold);
    if (!is_guard) check_bit(link_bus.pause_n, 1'b0);
    if (!is_guard) check_bit(link_bus.so_line, 1'b1);
    guard_n_i = 1'b1;
    pause_i = 1'b0;
  endtask
  initial begin
    int i;
    tick(16);
    rst_i = 1'b0;
    tick(1);
    check_bit(latch_o, 1'b0);
    check_bit(busy_o, 1'b0);
    check_bit(armed_o, 1'b0);
    check_bit(link_bus.so_line, 1'b1);
    check_bit(rd_ok_o, 1'b0);
    for (i = 0; i < 100 && rd_ok_o !== 1'b1; i++) tick(1);
    check_bit(rd_ok_o, 1'b1);
    check_bit(wr_ok_o, 1'b0);
    $display("power-up test done");
    run_cmd(sep_pkg::SEP_SET, 8'h00, 32'h00000000, 3'h1);
    check_bit(latch_o, 1'b1);
    check_bit(armed_o, 1'b1);
    run_cmd(sep_pkg::SEP_WR, 8'h10, 32'h11000000, 3'h1);
    check_bit(latch_o, 1'b0);
    run_cmd(sep_pkg::SEP_WR, 8'h10, 32'h22000000, 3'h1);
    run_cmd(sep_pkg::SEP_RD, 8'h10, 32'h00000000, 3'h1);
    check_word({24'h000000, got[7:0]}, 32'h00000011);
    run_cmd(sep_pkg::SEP_SET, 8'h00, 32'h00000000, 3'h1);
    run_cmd(sep_pkg::SEP_CLR, 8'h00, 32'h00000000, 3'h1);
    check_bit(latch_o, 1'b0);
    run_cmd(sep_pkg::SEP_SET, 8'h00, 32'h00000000, 3'h1);
    guard_n_i = 1'b0;
    tick(10);
    check_bit(latch_o, 1'b0);
    guard_n_i = 1'b1;
    tick(10);
    $display("latch test done");
    run_cmd(sep_pkg::SEP_SET, 8'h00, 32'h00000000, 3'h1);
    run_cmd(sep_pkg::SEP_WR, 8'h42, 32'h01020304, 3'h4);
    run_cmd(sep_pkg::SEP_RD, 8'h40, 32'h00000000, 3'h4);
    check_word(got, 32'h03040102);
    $display("page test done");
    run_cmd(sep_pkg::SEP_SET, 8'h00, 32'h00000000, 3'h1);
    fork
      run_cmd(sep_pkg::SEP_WR, 8'h44, 32'hAABB0000, 3'h2);
      poke(150, 40, 1'b0);
    join
    fork
      run_cmd(sep_pkg::SEP_RD, 8'h44, 32'h00000000, 3'h2);
      poke(262, 40, 1'b0);
    join
    check_word({16'h0000, got[15:0]}, 32'h0000AABB);
    $display("pause test done");
    run_cmd(sep_pkg::SEP_SET, 8'h00, 32'h00000000, 3'h1);
    fork
      run_cmd(sep_pkg::SEP_WR, 8'h42, 32'h77000000, 3'h1);
      poke(150, 200, 1'b1);
    join
    check_bit(latch_o, 1'b0);
    run_cmd(sep_pkg::SEP_RD, 8'h42, 32'h00000000, 3'h1);
    check_word({24'h000000, got[7:0]}, 32'h00000001);
    $display("guard test done");
    complete_run();
  end
endmodule // tb
